/* File: src/record_id_text.sv */
// renders a record identifier as zero-padded ascii digits joined by a hyphen
`include "weighing_record_logger_defs.svh"
module record_id_text
   import weighing_record_logger_pkg::*;
(
   input wire weighing_record_logger_pkg::rec_id_t id, // identifier to render
   input wire logic rejected, // render NO instead
   output logic [7:0] chars [0:11] // character 0 sent first
);
   function automatic logic [7:0] digit(input logic [19:0] v, input int unsigned pw);
      logic [19:0] q;
      q = (v / 20'(pw)) % 20'd10;
      return `CH_ZERO + q[7:0];
   endfunction : digit
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         chars[i] = 8'h20;
      end
      if (rejected) begin
         chars[0] = `CH_N;
         chars[1] = `CH_O;
      end else begin
         chars[0] = digit({12'h000, id.wrap}, 10000);
         chars[1] = digit({12'h000, id.wrap}, 1000);
         chars[2] = digit({12'h000, id.wrap}, 100);
         chars[3] = digit({12'h000, id.wrap}, 10);
         chars[4] = digit({12'h000, id.wrap}, 1);
         chars[5] = `CH_HYPHEN;
         chars[6] = digit({2'h0, id.record}, 100000);
         chars[7] = digit({2'h0, id.record}, 10000);
         chars[8] = digit({2'h0, id.record}, 1000);
         chars[9] = digit({2'h0, id.record}, 100);
         chars[10] = digit({2'h0, id.record}, 10);
         chars[11] = digit({2'h0, id.record}, 1);
      end
   end
endmodule : record_id_text

/* File: src/weighing_record_logger.sv */
// weighing record logger: saves, tags, reports and looks up weighing records
// Functional notes
// - A serial save command or save key creates a new record.
// - Successful save sends gross, tare and identifier to the host.
// - Record counter spans 0 to 131072, shown as six digits.
// - Each save but the first into an empty store increments record; at 131072 it wraps and wrap advances.
// - Save needs weight non-negative, stable, not under or overloaded.
// - Approved configuration also needs weight above twenty divisions.
// - Key save only while print re-arm allows printing.
// - Failed serial save answers NO; failed key save sends nothing.
// - Manual lookup asks wrap 0..255 and record 0..131072.
// - Verifiable when wrap equals current and record not above last.
// - Also verifiable when wrap one below and record above last.
// - Verified lookup steps scale, unit, gross, tare; cancel exits.
// - Lookup on empty store shows vacant for one second.
// - Failed verification shows invalid indication then returns.
// - Initialise erases every record at once, never singly.
// - Initialise is refused in approved configuration.
// - Records readable by host serial port and local display.
// - Re-arm modes: after leaving zero, always, after instability.
// - Stability threshold zero disables the check; else deviation limit.
`include "weighing_record_logger_defs.svh"
module weighing_record_logger
   import weighing_record_logger_pkg::*;
#(
   parameter int unsigned VACANT_CYCLES = `VACANT_CYCLES, // one second indication
   parameter int unsigned DEPTH_BITS = 6 // log2 of record slots held
) (
   input wire logic core_clk, // system clock
   input wire logic resetn, // synchronous reset, active low
   input wire weighing_record_logger_pkg::weight_t weight, // current weighing data
   input wire logic [23:0] deviation, // weight deviation in divisions
   input wire logic [7:0] stab_threshold, // 0 disables stability check
   input wire logic [1:0] rearm_mode, // print re-arm mode
   input wire logic approved, // legally approved configuration
   input wire logic [1:0] scale_num, // active scale number
   input wire logic [1:0] unit_sel, // active unit code
   input wire logic save_cmd, // store_weighing_cmd pulse from host port
   input wire logic save_key, // save key pulse
   input wire logic lookup_key, // lookup key pulse
   input wire weighing_record_logger_pkg::rec_id_t lookup_id, // operator-entered id
   input wire logic lookup_enter, // operator confirms lookup_id
   input wire logic step_key, // advance view item
   input wire logic cancel_key, // return to weighing
   input wire logic host_read, // host reads record at lookup_id
   input wire logic init_req, // initialise store
   input wire logic nv_busy, // persistent store busy
   output logic nv_we, // write record to persistent store
   output logic [DEPTH_BITS-1:0] nv_addr, // slot address
   output logic [77:0] nv_wdata, // {gross,tare,scale,unit,id}
   output logic nv_erase, // bulk erase pulse
   output logic tx_valid, // host frame ready, one pulse
   output logic [23:0] tx_gross, // frame gross
   output logic [23:0] tx_tare, // frame tare
   output logic [7:0] tx_id_chars [0:11], // frame identifier text
   output logic tx_read_bad, // host read refused
   output logic prompt_active, // operator asked for identifier
   output logic vacant_show, // store_vacant_msg indication
   output logic invalid_show, // invalid identifier indication
   output logic view_active, // record view shown
   output weighing_record_logger_pkg::view_t view_item, // item on display
   output logic [23:0] view_value, // value for item on display
   output weighing_record_logger_pkg::rec_id_t cur_id, // last saved identifier
   output logic store_empty // no records held
);
   typedef struct packed {
      mode_t mode;
      rec_id_t id;
      logic empty;
      logic armed;
      logic prev_zero;
      logic prev_unstable;
      logic prompt;
      logic [31:0] timer;
      logic tx_valid;
      logic [23:0] tx_gross;
      logic [23:0] tx_tare;
      rec_id_t tx_id;
      logic tx_no;
      logic tx_bad;
      logic nv_we;
      logic [DEPTH_BITS-1:0] nv_addr;
      logic [77:0] nv_wdata;
      logic nv_erase;
      view_t view;
      logic [23:0] view_value;
      rec_id_t sel;
   } state_t;
   state_t s, next_s;
   // shadow of the persistent slots so lookups answer without a read latency
   logic [77:0] slots [0:(1<<DEPTH_BITS)-1];
   logic stable, weight_ok, id_ok_op, id_ok_host;
   logic [77:0] rd_op, rd_host;
   logic [7:0] chars [0:11];

   function automatic logic verify(input rec_id_t q, input rec_id_t c, input logic e);
      logic ok;
      ok = 1'b0;
      if (!e && q.wrap <= `WRAP_MAX && q.record <= `RECORD_MAX) begin
         if (q.wrap == c.wrap && q.record <= c.record) begin
            ok = 1'b1;
         end
         if (c.wrap != 8'h00 && q.wrap == c.wrap - 8'h01 && q.record > c.record) begin
            ok = 1'b1;
         end
      end
      return ok;
   endfunction : verify

   assign stable = (stab_threshold == 8'h00) || (deviation <= {16'h0000, stab_threshold});
   assign weight_ok = !weight.gross[23] && stable && !weight.under && !weight.over
      && (!approved || ($signed(weight.gross) > $signed(`APPROVED_MIN_DIV)));
   assign id_ok_op = verify(lookup_id, s.id, s.empty);
   assign id_ok_host = verify(lookup_id, s.id, s.empty);
   assign rd_op = slots[lookup_id.record[DEPTH_BITS-1:0]];
   assign rd_host = rd_op;

   record_id_text u_text (
      .id(s.tx_id),
      .rejected(s.tx_no),
      .chars(chars)
   );

   always_comb begin
      rec_id_t nid;
      logic key_go, cmd_go;
      nid = s.id;
      key_go = 1'b0;
      cmd_go = 1'b0;
      next_s = s;
      next_s.tx_valid = 1'b0;
      next_s.tx_bad = 1'b0;
      next_s.nv_we = 1'b0;
      next_s.nv_erase = 1'b0;
      next_s.prev_zero = (weight.gross == 24'h000000);
      next_s.prev_unstable = !stable;
      unique case (rearm_mode)
         `REARM_ALWAYS: next_s.armed = 1'b1;
         `REARM_UNSTABLE: if (s.prev_unstable && stable) next_s.armed = 1'b1;
         default: if (s.prev_zero && weight.gross != 24'h000000) next_s.armed = 1'b1;
      endcase
      if (s.empty) begin
         nid = '0;
      end else if (s.id.record >= `RECORD_MAX) begin
         nid.record = '0;
         nid.wrap = s.id.wrap + 8'h01;
      end else begin
         nid.record = s.id.record + 18'h00001;
      end
      unique case (s.mode)
         ST_IDLE: begin
            cmd_go = save_cmd && !nv_busy;
            key_go = save_key && !save_cmd && !nv_busy && s.armed;
            if (cmd_go || key_go) begin
               next_s.tx_gross = weight.gross;
               next_s.tx_tare = weight.tare;
               if (weight_ok) begin
                  next_s.id = nid;
                  next_s.empty = 1'b0;
                  next_s.tx_id = nid;
                  next_s.tx_no = 1'b0;
                  next_s.nv_we = 1'b1;
                  next_s.nv_addr = nid.record[DEPTH_BITS-1:0];
                  next_s.nv_wdata = {weight.gross, weight.tare, scale_num, unit_sel, nid};
                  if (rearm_mode != `REARM_ALWAYS) next_s.armed = 1'b0;
                  next_s.mode = ST_SEND;
               end else if (cmd_go) begin
                  next_s.tx_no = 1'b1;
                  next_s.mode = ST_SEND;
               end
            end else if (host_read) begin
               next_s.tx_gross = rd_host[77:54];
               next_s.tx_tare = rd_host[53:30];
               next_s.tx_id = lookup_id;
               next_s.tx_no = !id_ok_host;
               next_s.tx_bad = !id_ok_host;
               next_s.mode = ST_SEND;
            end else if (init_req && !approved) begin
               next_s.nv_erase = 1'b1;
               next_s.id = '0;
               next_s.empty = 1'b1;
               next_s.mode = ST_ERASE;
            end else if (lookup_key) begin
               if (s.empty) begin
                  next_s.timer = 32'(VACANT_CYCLES - 1);
                  next_s.mode = ST_VACANT;
               end else begin
                  next_s.prompt = 1'b1;
               end
            end else if (s.prompt && cancel_key) begin
               next_s.prompt = 1'b0;
            end else if (s.prompt && lookup_enter) begin
               next_s.prompt = 1'b0;
               next_s.sel = lookup_id;
               if (id_ok_op) begin
                  next_s.view = VIEW_SCALE;
                  next_s.view_value = {22'h0, rd_op[29:28]};
                  next_s.mode = ST_SHOW;
               end else begin
                  next_s.timer = 32'(VACANT_CYCLES - 1);
                  next_s.mode = ST_INVALID;
               end
            end
         end
         ST_SEND: begin
            next_s.tx_valid = 1'b1;
            next_s.mode = ST_IDLE;
         end
         ST_SHOW: begin
            if (cancel_key) begin
               next_s.mode = ST_IDLE;
            end else if (step_key) begin
               unique case (s.view)
                  VIEW_SCALE: begin
                     next_s.view = VIEW_UNIT;
                     next_s.view_value = {22'h0, rd_op[27:26]};
                  end
                  VIEW_UNIT: begin
                     next_s.view = VIEW_GROSS;
                     next_s.view_value = rd_op[77:54];
                  end
                  VIEW_GROSS: begin
                     next_s.view = VIEW_TARE;
                     next_s.view_value = rd_op[53:30];
                  end
                  default: begin
                     next_s.view = VIEW_SCALE;
                     next_s.view_value = {22'h0, rd_op[29:28]};
                  end
               endcase
            end
         end
         ST_VACANT, ST_INVALID: begin
            if (s.timer == 32'h00000000) begin
               next_s.mode = ST_IDLE;
            end else begin
               next_s.timer = s.timer - 32'h00000001;
            end
         end
         ST_ERASE: begin
            if (!nv_busy) next_s.mode = ST_IDLE;
         end
         default: next_s.mode = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s <= '0;
         s.empty <= 1'b1;
         s.mode <= ST_IDLE;
         s.view <= VIEW_SCALE;
      end else begin
         s <= next_s;
      end
   end

   // lookup keys index the slot by record number; older slots get overwritten
   always_ff @(posedge core_clk) begin
      if (next_s.nv_we) begin
         slots[next_s.nv_addr] <= next_s.nv_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         for (int i = 0; i < 12; i++) tx_id_chars[i] <= 8'h20;
      end else if (s.mode == ST_SEND) begin
         for (int i = 0; i < 12; i++) tx_id_chars[i] <= chars[i];
      end
   end

   assign nv_we = s.nv_we;
   assign nv_addr = s.nv_addr;
   assign nv_wdata = s.nv_wdata;
   assign nv_erase = s.nv_erase;
   assign tx_valid = s.tx_valid;
   assign tx_gross = s.tx_gross;
   assign tx_tare = s.tx_tare;
   assign tx_read_bad = s.tx_bad;
   assign prompt_active = s.prompt;
   assign vacant_show = (s.mode == ST_VACANT);
   assign invalid_show = (s.mode == ST_INVALID);
   assign view_active = (s.mode == ST_SHOW);
   assign view_item = s.view;
   assign view_value = s.view_value;
   assign cur_id = s.id;
   assign store_empty = s.empty;
endmodule : weighing_record_logger

/* File: src/weighing_record_logger_defs.svh */
// constants for the weighing record logger
`ifndef WEIGHING_RECORD_LOGGER_DEFS_SVH
`define WEIGHING_RECORD_LOGGER_DEFS_SVH
`define WRAP_MAX 8'hFF
`define RECORD_MAX 18'h20000
`define APPROVED_MIN_DIV 24'h000014
`define WRAP_DIGITS 5
`define RECORD_DIGITS 6
`define CLK_HZ 10000000
`define VACANT_MS 1000
`define VACANT_CYCLES ((`CLK_HZ / 1000) * `VACANT_MS)
`define REARM_LEAVE_ZERO 2'h0
`define REARM_ALWAYS 2'h1
`define REARM_UNSTABLE 2'h2
`define CH_HYPHEN 8'h2D
`define CH_N 8'h4E
`define CH_O 8'h4F
`define CH_ZERO 8'h30
`endif

/* File: src/weighing_record_logger_pkg.sv */
// types shared by the weighing record logger
package weighing_record_logger_pkg;
   typedef struct packed {
      logic [23:0] gross; // gross weight in divisions, signed
      logic [23:0] tare;
      logic stable_raw; // filter reports stable
      logic under;
      logic over;
   } weight_t;
   typedef struct packed {
      logic [7:0] wrap;
      logic [17:0] record;
   } rec_id_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SEND = 3'b001,
      ST_SHOW = 3'b010,
      ST_VACANT = 3'b011,
      ST_INVALID = 3'b100,
      ST_ERASE = 3'b101
   } mode_t;
   typedef enum logic [2:0] {
      VIEW_SCALE = 3'b000,
      VIEW_UNIT = 3'b001,
      VIEW_GROSS = 3'b010,
      VIEW_TARE = 3'b011
   } view_t;
endpackage : weighing_record_logger_pkg

/* File: test/nv_store_model.sv */
// persistent store stand-in: goes busy after each write or erase
module nv_store_model (
   input wire logic core_clk, // clock
   input wire logic resetn, // sync reset, active low
   input wire logic nv_we, // record write
   input wire logic nv_erase, // bulk erase
   input wire logic slow, // longer busy time
   output logic nv_busy // store busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   always_ff @(posedge core_clk) begin
      if (!resetn) cnt <= 0;
      else if (nv_we || nv_erase) cnt <= slow ? 6 : 1;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   assign nv_busy = cnt > 0;
endmodule : nv_store_model

/* File: test/tb_top.sv */
// self-checking bench for the weighing record logger
`include "weighing_record_logger_defs.svh"
module tb_top
   import weighing_record_logger_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, resetn = 0, approved = 0, slow = 0, nv_busy;
   weight_t weight = '0;
   logic [23:0] deviation = '0, tx_gross, tx_tare, view_value, last_g;
   logic [7:0] stab_threshold = '0, pul = '0;
   logic [1:0] rearm_mode = `REARM_ALWAYS, scale_num = 2'h1, unit_sel = 2'h2;
   rec_id_t lookup_id = '0, cur_id;
   logic nv_we, nv_erase, tx_valid, tx_read_bad, prompt_active, vacant_show;
   logic invalid_show, view_active, store_empty;
   logic [77:0] nv_wdata;
   logic bad_q = 1'b0;
   logic [5:0] nv_addr;
   logic [7:0] tx_id_chars [0:11];
   logic [95:0] txt;
   view_t view_item;
   int err_count = 0, n_checks = 0, wrap = 0, rec = 0, nsaved = 0;
   logic [31:0] seed = 32'hEE94;
   wire [5:0] obs = {vacant_show, invalid_show, view_active, tx_valid, nv_erase, !nv_busy};
   always #50 core_clk = ~core_clk;
   // the refusal flag leads the frame pulse by one cycle
   always @(posedge core_clk) bad_q <= tx_read_bad;
   always_comb for (int i = 0; i < 12; i++) txt[95-8*i -: 8] = tx_id_chars[i];
   weighing_record_logger #(.VACANT_CYCLES(20)) DUT (.core_clk(core_clk), .resetn(resetn),
      .weight(weight), .deviation(deviation), .stab_threshold(stab_threshold),
      .rearm_mode(rearm_mode), .approved(approved), .scale_num(scale_num), .unit_sel(unit_sel),
      .save_cmd(pul[0]), .save_key(pul[1]), .lookup_key(pul[2]), .lookup_id(lookup_id),
      .lookup_enter(pul[3]), .step_key(pul[4]), .cancel_key(pul[5]), .host_read(pul[6]),
      .init_req(pul[7]), .nv_busy(nv_busy), .nv_we(nv_we), .nv_addr(nv_addr),
      .nv_wdata(nv_wdata), .nv_erase(nv_erase), .tx_valid(tx_valid), .tx_gross(tx_gross),
      .tx_tare(tx_tare), .tx_id_chars(tx_id_chars), .tx_read_bad(tx_read_bad),
      .prompt_active(prompt_active), .vacant_show(vacant_show), .invalid_show(invalid_show),
      .view_active(view_active), .view_item(view_item), .view_value(view_value),
      .cur_id(cur_id), .store_empty(store_empty));
   nv_store_model store (.core_clk(core_clk), .resetn(resetn), .nv_we(nv_we),
      .nv_erase(nv_erase), .slow(slow), .nv_busy(nv_busy));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
   endfunction : lfsr
   function automatic logic [95:0] id_txt(input int w, input int r, input bit no);
      logic [95:0] s;
      s = {`CH_N, `CH_O, {10{8'h20}}};
      if (!no) begin
         for (int i = 0; i < 5; i++) s[95-8*i -: 8] = 8'(`CH_ZERO + (w / 10**(4-i)) % 10);
         s[55:48] = `CH_HYPHEN;
         for (int i = 0; i < 6; i++) s[47-8*i -: 8] = 8'(`CH_ZERO + (r / 10**(5-i)) % 10);
      end
      return s;
   endfunction : id_txt
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic pulse(input int k);
      @(negedge core_clk);
      pul[k] = 1'b1;
      @(negedge core_clk);
      pul[k] = 1'b0;
   endtask : pulse
   task automatic wait_sig(input int k, input int lim, output bit hit);
      hit = 0;
      for (int i = 0; i < lim && !hit; i++) begin
         @(posedge core_clk);
         #1;
         hit = (obs[k] === 1'b1);
      end
   endtask : wait_sig
   // a missing answer ends the run rather than letting later steps drift
   task automatic need(input int k, input int lim);
      bit h;
      wait_sig(k, lim, h);
      chk(h, 1'b1);
      if (!h) results();
   endtask : need
   initial begin
      bit h, acc, key;
      int g;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk) resetn = 1'b1;
      chk({store_empty, cur_id}, {1'b1, 26'h0});
      pulse(2);
      need(5, 40);
      repeat (30) @(negedge core_clk);
      chk({vacant_show, store_empty}, 2'b01);
      $display("test empty lookup done");
      for (int n = 0; n < 25; n++) begin
         seed = lfsr(seed);
         // last pass forces a clean save so the lookups below have a record
         if (n == 24) seed = 32'h00000640;
         g = seed[3] ? -int'(seed[9:4]) : int'(seed[11:4]);
         @(negedge core_clk);
         weight = '{24'(g), 24'(seed[31:24]), 1'b1, seed[12] & seed[13], seed[14] & seed[15]};
         deviation = 24'(seed[19:16]);
         stab_threshold = 8'(seed[21:20]);
         approved = seed[22];
         key = seed[23];
         slow = seed[25];
         acc = g >= 0 && (seed[21:20] == 0 || seed[19:16] <= seed[21:20]) && !weight.under &&
            !weight.over && (!approved || g > 20);
         pulse(key ? 1 : 0);
         wait_sig(2, 6, h);
         chk(h, acc | !key);
         if (acc) begin
            if (nsaved == 0) {wrap, rec} = {32'h0, 32'h0};
            else if (rec == 131072) {wrap, rec} = {wrap + 1, 32'h0};
            else rec++;
            nsaved++;
            last_g = 24'(g);
            chk({tx_gross, tx_tare}, {weight.gross, weight.tare});
         end
         if (h) chk(txt, id_txt(wrap, rec, !acc));
         chk(cur_id, {8'(wrap), 18'(rec)});
         need(0, 20);
      end
      rearm_mode = `REARM_LEAVE_ZERO;
      for (int k = 0; k < 3; k++) begin
         if (k == 2) begin
            weight.gross = 24'h0;
            repeat (2) @(negedge core_clk);
            weight.gross = last_g;
            repeat (2) @(negedge core_clk);
         end
         pulse(1);
         wait_sig(2, 6, h);
         chk(h, k != 1);
         if (h) rec++;
         chk(cur_id, {8'(wrap), 18'(rec)});
         need(0, 20);
      end
      $display("test saves done");
      lookup_id = {8'(wrap), 18'(rec)};
      pulse(2);
      chk(prompt_active, 1'b1);
      pulse(3);
      need(3, 4);
      chk(view_item, VIEW_SCALE);
      pulse(4);
      chk(view_item, VIEW_UNIT);
      pulse(4);
      chk({view_item, view_value}, {VIEW_GROSS, last_g});
      pulse(4);
      chk({view_item, view_value}, {VIEW_TARE, 24'h0});
      pulse(5);
      @(negedge core_clk);
      chk(view_active, 1'b0);
      lookup_id = {8'(wrap), 18'(rec + 1)};
      pulse(2);
      pulse(3);
      need(4, 4);
      repeat (30) @(negedge core_clk);
      $display("test lookups done");
      lookup_id = {8'(wrap), 18'(rec)};
      pulse(6);
      need(2, 4);
      chk({bad_q, tx_gross}, {1'b0, last_g});
      lookup_id = {8'(wrap + 1), 18'h0};
      pulse(6);
      need(2, 4);
      chk({bad_q, txt}, {1'b1, id_txt(0, 0, 1)});
      $display("test host reads done");
      approved = 1'b1;
      pulse(7);
      chk(nv_erase, 1'b0);
      approved = 1'b0;
      pulse(7);
      chk(nv_erase, 1'b1);
      need(0, 20);
      chk({store_empty, cur_id}, {1'b1, 26'h0});
      $display("test erase done");
      results();
   end
endmodule : tb_top

/* File: test/weighing_record_logger_monitor.sv */
// port assertions for the weighing record logger
`include "weighing_record_logger_defs.svh"
module weighing_record_logger_monitor
   import weighing_record_logger_pkg::*;
#(
   parameter int unsigned VACANT_CYCLES = 20 // indication length
) (
   input wire logic core_clk, // clock
   input wire logic resetn, // sync reset, active low
   input wire weighing_record_logger_pkg::weight_t weight, // weighing data
   input wire logic approved, // approved configuration
   input wire logic save_cmd, // host save
   input wire logic save_key, // key save
   input wire logic nv_we, // record write
   input wire logic nv_erase, // bulk erase
   input wire logic tx_valid, // frame pulse
   input wire logic tx_read_bad, // read refused
   input wire logic [7:0] tx_id_chars [0:11], // frame id text
   input wire logic vacant_show, // empty indication
   input wire weighing_record_logger_pkg::rec_id_t cur_id, // last id
   input wire logic store_empty // no records
);
   int unsigned vcnt;
   // counts how long the empty indication has stood
   always_ff @(posedge core_clk) begin
      if (!resetn) vcnt <= 0;
      else vcnt <= vacant_show ? vcnt + 1 : 0;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_frame;
      nv_we ##1 tx_valid;
   endsequence
   a_save_frame: assert property (nv_we |-> s_frame)
      else $error("save gave no frame");
   a_bad_weight: assert property ((save_cmd || save_key) &&
      (weight.gross[23] || weight.under || weight.over) |=> !nv_we) else $error("bad weight saved");
   a_small_weight: assert property (approved && (save_cmd || save_key) &&
      $signed(weight.gross) <= $signed(`APPROVED_MIN_DIV) |=> !nv_we) else $error("light weight saved");
   a_count_step: assert property (nv_we && !$past(store_empty) |-> cur_id.record ==
      ($past(cur_id.record) == `RECORD_MAX ? 18'h0 : $past(cur_id.record) + 18'h1))
      else $error("record count step wrong");
   a_record_max: assert property (cur_id.record <= `RECORD_MAX)
      else $error("record count out of range");
   a_refuse_text: assert property (tx_read_bad |=> tx_valid && tx_id_chars[0] == `CH_N &&
      tx_id_chars[1] == `CH_O) else $error("refusal text wrong");
   a_id_hyphen: assert property (tx_valid && $past(nv_we) |-> tx_id_chars[5] == `CH_HYPHEN)
      else $error("id separator wrong");
   a_erase_gate: assert property (nv_erase |-> !approved)
      else $error("erase while approved");
   a_erase_clear: assert property (nv_erase |-> ##[0:2] (store_empty && cur_id == '0))
      else $error("erase left counters");
   a_vacant_len: assert property ($fell(vacant_show) |-> vcnt == VACANT_CYCLES)
      else $error("empty indication length wrong");
endmodule : weighing_record_logger_monitor
bind weighing_record_logger weighing_record_logger_monitor #(.VACANT_CYCLES(VACANT_CYCLES)) mon (
   .core_clk(core_clk), .resetn(resetn), .weight(weight), .approved(approved),
   .save_cmd(save_cmd), .save_key(save_key), .nv_we(nv_we), .nv_erase(nv_erase),
   .tx_valid(tx_valid), .tx_read_bad(tx_read_bad), .tx_id_chars(tx_id_chars),
   .vacant_show(vacant_show), .cur_id(cur_id), .store_empty(store_empty));
